/* File: include/liet_params.svh */
// Register map, field positions and reset values of the error/timer block.
// Assumes a 32-bit APB register bus and 16-byte register slots.
`ifndef LIET_PARAMS_SVH
`define LIET_PARAMS_SVH

// ----------------------------------------------------------------------
// Register window
// ----------------------------------------------------------------------
`define LIET_WIN_BITS     12
`define LIET_SLOT_LSB     4
`define LIET_OFF_ESR      12'h280
`define LIET_OFF_TMR_LVT  12'h320
`define LIET_OFF_ERR_LVT  12'h370
`define LIET_OFF_INIT_CNT 12'h380
`define LIET_OFF_CUR_CNT  12'h390
`define LIET_OFF_DIV_CFG  12'h3e0

// ----------------------------------------------------------------------
// Error status bits
// ----------------------------------------------------------------------
`define LIET_ESR_W        8
`define LIET_ESR_SND_CSUM 0
`define LIET_ESR_RCV_CSUM 1
`define LIET_ESR_SND_ACC  2
`define LIET_ESR_RCV_ACC  3
`define LIET_ESR_SND_VEC  5
`define LIET_ESR_RCV_VEC  6
`define LIET_ESR_ILL_REG  7

// ----------------------------------------------------------------------
// Vector-table entry fields and reset values
// ----------------------------------------------------------------------
`define LIET_LVT_VEC_W    8
`define LIET_LVT_STAT_BIT 12
`define LIET_LVT_MASK_BIT 16
`define LIET_LVT_MODE_BIT 17
`define LIET_LVT_RST      32'h0001_0000
`define LIET_VEC_MIN      8'h10
`define LIET_DIV_RST      8'h01

`endif

/* File: include/liet_pkg.sv */
// Types shared by the error/timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package liet_pkg;

   // Delivery handshake towards the core
   typedef enum logic [1:0] {
      LIET_DLV_IDLE  = 2'b00,
      LIET_DLV_OFFER = 2'b01,
      LIET_DLV_RETRY = 2'b10
   } liet_dlv_t;

   // Source of the interrupt being offered
   typedef enum logic {
      LIET_SRC_TMR = 1'b0,
      LIET_SRC_ERR = 1'b1
   } liet_src_t;

endpackage

/* File: logic/liet_top.sv */
// Error status, local timer and local interrupt delivery of the interrupt unit.
// Assumes an APB master, a core that accepts or refuses each offered
// interrupt, and a message bus that reports faults as one-cycle pulses.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "liet_params.svh"

module liet_top
#(
   parameter int DIV_W = 8
)
(
   input  wire logic        I_REF_CLK,
   input  wire logic        I_SYS_RST,
   input  wire logic [19:0] I_BASE_ADDR,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [31:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_SND_CSUM_ERR,
   input  wire logic        I_RCV_CSUM_ERR,
   input  wire logic        I_SND_ACC_ERR,
   input  wire logic        I_RCV_ACC_ERR,
   input  wire logic        I_SND_VLD,
   input  wire logic [7:0]  I_SND_VEC,
   input  wire logic        I_RCV_VLD,
   input  wire logic [7:0]  I_RCV_VEC,
   output logic             O_INT_REQ,
   output logic      [7:0]  O_INT_VEC,
   input  wire logic        I_CORE_ACCEPT,
   input  wire logic        I_CORE_REFUSE
);

   // -------------------------------------------------------------------
   // Elaboration check
   // -------------------------------------------------------------------
   generate
      if (DIV_W < 1 || DIV_W > 16)
      begin : g_bad_div
         $error("DIV_W must lie in 1..16");
      end
   endgenerate

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic vec_bad(input logic [7:0] v);
      vec_bad = (v < `LIET_VEC_MIN);
   endfunction

   function automatic logic slot_is(input logic [11:0] a,
                                    input logic [11:0] off);
      slot_is = (a[11:`LIET_SLOT_LSB] == off[11:`LIET_SLOT_LSB]);
   endfunction

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   logic [`LIET_ESR_W-1:0] err_live_ff;
   logic [`LIET_ESR_W-1:0] esr_ff;
   logic [`LIET_ESR_W-1:0] err_in;
   logic [`LIET_ESR_W-1:0] err_new;
   logic                   prev_esr_wr_ff;
   logic [31:0]            tmr_lvt_ff;
   logic [31:0]            err_lvt_ff;
   logic [31:0]            init_ff;
   logic [31:0]            cur_ff;
   logic                   run_ff;
   logic [DIV_W-1:0]       div_ff;
   logic [DIV_W-1:0]       pre_ff;
   logic                   tick;
   logic                   tmr_zero;
   logic                   tmr_pend_ff;
   logic                   err_pend_ff;
   liet_pkg::liet_dlv_t    dlv_ff;
   liet_pkg::liet_src_t    src_ff;
   logic [31:0]            rd_mux;
   logic                   in_win;
   logic                   mapped;
   logic                   acc;
   logic                   wr_acc;
   logic                   esr_wr;
   logic                   err_evt;
   logic                   tmr_ok;
   logic                   accepted;
   logic [11:0]            off;

   // -------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------
   assign off    = I_PADDR[11:0];
   assign in_win = (I_PADDR[31:`LIET_WIN_BITS] == I_BASE_ADDR);
   assign mapped = slot_is(off, `LIET_OFF_ESR)
                 | slot_is(off, `LIET_OFF_TMR_LVT)
                 | slot_is(off, `LIET_OFF_ERR_LVT)
                 | slot_is(off, `LIET_OFF_INIT_CNT)
                 | slot_is(off, `LIET_OFF_CUR_CNT)
                 | slot_is(off, `LIET_OFF_DIV_CFG);
   assign acc    = I_PSEL & I_PENABLE;
   assign wr_acc = acc & I_PWRITE & in_win;
   assign esr_wr = wr_acc & slot_is(off, `LIET_OFF_ESR);
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = acc & ~in_win;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (slot_is(off, `LIET_OFF_ESR))
         rd_mux[`LIET_ESR_W-1:0] = esr_ff;
      else if (slot_is(off, `LIET_OFF_TMR_LVT))
      begin
         rd_mux = tmr_lvt_ff;
         rd_mux[`LIET_LVT_STAT_BIT] = tmr_pend_ff;
      end
      else if (slot_is(off, `LIET_OFF_ERR_LVT))
      begin
         rd_mux = err_lvt_ff;
         rd_mux[`LIET_LVT_STAT_BIT] = err_pend_ff;
      end
      else if (slot_is(off, `LIET_OFF_INIT_CNT))
         rd_mux = init_ff;
      else if (slot_is(off, `LIET_OFF_CUR_CNT))
         rd_mux = cur_ff;
      else if (slot_is(off, `LIET_OFF_DIV_CFG))
         rd_mux[DIV_W-1:0] = div_ff;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         O_PRDATA <= 32'h0000_0000;
      else if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
         O_PRDATA <= in_win ? rd_mux : 32'h0000_0000;
   end

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         tmr_lvt_ff <= `LIET_LVT_RST;
         err_lvt_ff <= `LIET_LVT_RST;
         div_ff     <= DIV_W'(`LIET_DIV_RST);
      end
      else if (wr_acc)
      begin
         if (slot_is(off, `LIET_OFF_TMR_LVT))
         begin
            tmr_lvt_ff <= 32'h0000_0000;
            tmr_lvt_ff[`LIET_LVT_VEC_W-1:0] <= I_PWDATA[7:0];
            tmr_lvt_ff[`LIET_LVT_MASK_BIT] <=
               I_PWDATA[`LIET_LVT_MASK_BIT];
            tmr_lvt_ff[`LIET_LVT_MODE_BIT] <=
               I_PWDATA[`LIET_LVT_MODE_BIT];
         end
         if (slot_is(off, `LIET_OFF_ERR_LVT))
         begin
            err_lvt_ff <= 32'h0000_0000;
            err_lvt_ff[`LIET_LVT_VEC_W-1:0] <= I_PWDATA[7:0];
            err_lvt_ff[`LIET_LVT_MASK_BIT] <=
               I_PWDATA[`LIET_LVT_MASK_BIT];
         end
         if (slot_is(off, `LIET_OFF_DIV_CFG))
            div_ff <= I_PWDATA[DIV_W-1:0];
      end
   end

   // -------------------------------------------------------------------
   // Error sources
   // -------------------------------------------------------------------
   assign tmr_ok = ~vec_bad(tmr_lvt_ff[7:0]);
   always_comb
   begin
      err_in = '0;
      err_in[`LIET_ESR_SND_CSUM] = I_SND_CSUM_ERR;
      err_in[`LIET_ESR_RCV_CSUM] = I_RCV_CSUM_ERR;
      err_in[`LIET_ESR_SND_ACC]  = I_SND_ACC_ERR;
      err_in[`LIET_ESR_RCV_ACC]  = I_RCV_ACC_ERR;
      err_in[`LIET_ESR_SND_VEC]  = I_SND_VLD & vec_bad(I_SND_VEC);
      err_in[`LIET_ESR_RCV_VEC]  = (I_RCV_VLD & vec_bad(I_RCV_VEC))
                                 | (tmr_zero & ~tmr_ok);
      err_in[`LIET_ESR_ILL_REG]  = acc & in_win & ~mapped;
   end

   // Nothing recorded while the error entry is masked
   assign err_new = err_lvt_ff[`LIET_LVT_MASK_BIT] ? '0
                  : (err_in & ~err_live_ff);
   assign err_evt = |err_new;

   // -------------------------------------------------------------------
   // Error status
   // -------------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         err_live_ff <= '0;
      else if (esr_wr & prev_esr_wr_ff)
         err_live_ff <= err_new;
      else
         err_live_ff <= err_live_ff | err_new;
   end

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         esr_ff <= '0;
      else if (esr_wr & prev_esr_wr_ff)
         esr_ff <= '0;
      else if (esr_wr)
         esr_ff <= err_live_ff | err_new;
   end

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         prev_esr_wr_ff <= 1'b0;
      else if (acc)
         prev_esr_wr_ff <= esr_wr & ~prev_esr_wr_ff;
   end

   // -------------------------------------------------------------------
   // Timer
   // -------------------------------------------------------------------
   assign tick = (pre_ff + DIV_W'(1) >= div_ff);

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         pre_ff <= '0;
      else if (tick)
         pre_ff <= '0;
      else
         pre_ff <= pre_ff + DIV_W'(1);
   end

   assign tmr_zero = run_ff & tick & (cur_ff == 32'h0000_0001);

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         init_ff <= 32'h0000_0000;
      else if (wr_acc & slot_is(off, `LIET_OFF_INIT_CNT))
         init_ff <= I_PWDATA;
   end

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         cur_ff <= 32'h0000_0000;
         run_ff <= 1'b0;
      end
      else if (wr_acc & slot_is(off, `LIET_OFF_INIT_CNT))
      begin
         cur_ff <= I_PWDATA;
         run_ff <= (I_PWDATA != 32'h0000_0000);
      end
      else if (tmr_zero)
      begin
         if (tmr_lvt_ff[`LIET_LVT_MODE_BIT])
         begin
            cur_ff <= init_ff;
            run_ff <= (init_ff != 32'h0000_0000);
         end
         else
         begin
            cur_ff <= 32'h0000_0000;
            run_ff <= 1'b0;
         end
      end
      else if (run_ff & tick)
         cur_ff <= cur_ff - 32'h0000_0001;
   end

   // -------------------------------------------------------------------
   // Pending interrupts, edge triggered
   // -------------------------------------------------------------------
   assign accepted = (dlv_ff == liet_pkg::LIET_DLV_OFFER) & I_CORE_ACCEPT;

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         tmr_pend_ff <= 1'b0;
      else if (tmr_zero & tmr_ok & ~tmr_lvt_ff[`LIET_LVT_MASK_BIT])
         tmr_pend_ff <= 1'b1;
      else if (accepted & (src_ff == liet_pkg::LIET_SRC_TMR))
         tmr_pend_ff <= 1'b0;
   end

   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         err_pend_ff <= 1'b0;
      else if (err_evt & ~vec_bad(err_lvt_ff[7:0]))
         err_pend_ff <= 1'b1;
      else if (accepted & (src_ff == liet_pkg::LIET_SRC_ERR))
         err_pend_ff <= 1'b0;
   end

   // -------------------------------------------------------------------
   // Delivery to the core
   // -------------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         dlv_ff    <= liet_pkg::LIET_DLV_IDLE;
         src_ff    <= liet_pkg::LIET_SRC_TMR;
         O_INT_REQ <= 1'b0;
         O_INT_VEC <= 8'h00;
      end
      else
      begin
         case (dlv_ff)
            liet_pkg::LIET_DLV_IDLE:
            begin
               if (tmr_pend_ff)
               begin
                  dlv_ff    <= liet_pkg::LIET_DLV_OFFER;
                  src_ff    <= liet_pkg::LIET_SRC_TMR;
                  O_INT_REQ <= 1'b1;
                  O_INT_VEC <= tmr_lvt_ff[7:0];
               end
               else if (err_pend_ff)
               begin
                  dlv_ff    <= liet_pkg::LIET_DLV_OFFER;
                  src_ff    <= liet_pkg::LIET_SRC_ERR;
                  O_INT_REQ <= 1'b1;
                  O_INT_VEC <= err_lvt_ff[7:0];
               end
            end
            liet_pkg::LIET_DLV_OFFER:
            begin
               if (I_CORE_ACCEPT)
               begin
                  dlv_ff    <= liet_pkg::LIET_DLV_IDLE;
                  O_INT_REQ <= 1'b0;
               end
               else if (I_CORE_REFUSE)
               begin
                  dlv_ff    <= liet_pkg::LIET_DLV_RETRY;
                  O_INT_REQ <= 1'b0;
               end
            end
            liet_pkg::LIET_DLV_RETRY:
            begin
               dlv_ff    <= liet_pkg::LIET_DLV_OFFER;
               O_INT_REQ <= 1'b1;
            end
            default:
            begin
               dlv_ff    <= liet_pkg::LIET_DLV_IDLE;
               O_INT_REQ <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_SYS_RST);

   esr_sticky_a: assert property (
      !(esr_wr & prev_esr_wr_ff) |=> (err_live_ff & $past(err_live_ff))
                                     == $past(err_live_ff))
      else $error("error bit lost without clear");

   esr_clear_a: assert property (
      (esr_wr & prev_esr_wr_ff) |=> esr_ff == '0)
      else $error("double write did not clear status");

   esr_update_a: assert property (
      (esr_wr & ~prev_esr_wr_ff) |=> esr_ff == err_live_ff)
      else $error("status read copy not updated");

   mask_hold_a: assert property (
      err_lvt_ff[`LIET_LVT_MASK_BIT] & !(esr_wr & prev_esr_wr_ff)
      |=> $stable(err_live_ff))
      else $error("error recorded while masked");

   ill_reg_a: assert property (
      (acc & in_win & ~mapped & ~err_lvt_ff[`LIET_LVT_MASK_BIT])
      |=> err_live_ff[`LIET_ESR_ILL_REG])
      else $error("reserved slot access not flagged");

   err_edge_a: assert property (
      err_pend_ff & ~accepted & ~err_evt |=> err_pend_ff)
      else $error("error interrupt pend dropped");

   oneshot_hold_a: assert property (
      tmr_zero & ~tmr_lvt_ff[`LIET_LVT_MODE_BIT] & ~wr_acc
      |=> cur_ff == 32'h0000_0000
          ##1 (cur_ff == 32'h0000_0000 || $past(wr_acc)))
      else $error("one-shot timer did not hold at zero");

   periodic_reload_a: assert property (
      tmr_zero & tmr_lvt_ff[`LIET_LVT_MODE_BIT] & ~wr_acc
      |=> cur_ff == $past(init_ff))
      else $error("periodic timer did not reload");

   restart_a: assert property (
      wr_acc & slot_is(off, `LIET_OFF_INIT_CNT) |=> cur_ff == $past(I_PWDATA))
      else $error("initial count write did not restart");

   tmr_mask_a: assert property (
      tmr_lvt_ff[`LIET_LVT_MASK_BIT] & ~tmr_pend_ff |=> ~tmr_pend_ff)
      else $error("masked timer interrupt pended");

   retry_a: assert property (
      (dlv_ff == liet_pkg::LIET_DLV_OFFER) & I_CORE_REFUSE & ~I_CORE_ACCEPT
      |=> ~O_INT_REQ ##1 O_INT_REQ)
      else $error("refused interrupt not offered again");

   vec_bad_a: assert property (
      I_SND_VLD & (I_SND_VEC < 8'h10) & ~err_lvt_ff[`LIET_LVT_MASK_BIT]
      |=> err_live_ff[`LIET_ESR_SND_VEC])
      else $error("illegal send vector not flagged");

   cov_periodic_c: cover property (
      tmr_zero & tmr_lvt_ff[`LIET_LVT_MODE_BIT]);
   cov_refuse_c: cover property (
      (dlv_ff == liet_pkg::LIET_DLV_OFFER) & I_CORE_REFUSE ##2 accepted);
   cov_clear_c: cover property (esr_wr & prev_esr_wr_ff);

endmodule

/* File: test/liet_core_model.sv */
// Core model: answers each offered local interrupt and logs the vector.
// Assumes offers stand until answered and answers are one-cycle pulses.
`timescale 1ns/10ps

module liet_core_model
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_req,
   input  wire logic [7:0] i_vec,
   input  wire logic [3:0] i_lat,
   input  wire logic       i_refuse_one,
   output logic            o_accept,
   output logic            o_refuse,
   output logic      [7:0] o_irr_vec,
   output int              o_acc_cnt,
   output int              o_ref_cnt
);
   logic [3:0] wait_ff;
   logic       refused_ff;

   // ------------------------------------------------------------------
   // Answer offers after i_lat cycles
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_accept   <= 1'b0;
         o_refuse   <= 1'b0;
         o_irr_vec  <= 8'h00;
         o_acc_cnt  <= 0;
         o_ref_cnt  <= 0;
         wait_ff    <= 4'h0;
         refused_ff <= 1'b0;
      end
      else
      begin
         o_accept <= 1'b0;
         o_refuse <= 1'b0;
         if (!i_refuse_one)
         begin
            refused_ff <= 1'b0;
         end
         if (i_req && !o_accept && !o_refuse)
         begin
            if (wait_ff < i_lat)
            begin
               wait_ff <= wait_ff + 4'h1;
            end
            else if (i_refuse_one && !refused_ff)
            begin
               wait_ff    <= 4'h0;
               o_refuse   <= 1'b1;
               refused_ff <= 1'b1;
               o_ref_cnt  <= o_ref_cnt + 1;
            end
            else
            begin
               wait_ff   <= 4'h0;
               o_accept  <= 1'b1;
               o_irr_vec <= i_vec;
               o_acc_cnt <= o_acc_cnt + 1;
            end
         end
      end
   end

endmodule

/* File: test/local_intc_error_timer_test.sv */
// Bench for the error/timer block: APB tasks and call sequences.
// Assumes the core model answers offers; bench drives bus fault pulses.
`timescale 1ns/10ps
`include "liet_params.svh"

module local_intc_error_timer_test;
   localparam logic [19:0] BASE = 20'h4a5b6;
   logic        clk, rst, psel, pen, pwr, pready, pslverr, e;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [3:0]  err_p, lat;
   logic        svld, rvld, ireq, acc, refu, ref_one;
   logic [7:0]  svec, rvec, ivec, irr_vec;
   int          acc_cnt, ref_cnt, miscompares, total_checks;
   logic [11:0] offs [6] = '{`LIET_OFF_TMR_LVT, `LIET_OFF_ERR_LVT,
      `LIET_OFF_INIT_CNT, `LIET_OFF_CUR_CNT, `LIET_OFF_DIV_CFG,
      `LIET_OFF_ESR};
   logic [31:0] rstv [6] = '{`LIET_LVT_RST, `LIET_LVT_RST, 32'h0, 32'h0,
      32'h0000_0001, 32'h0};

   liet_top dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_BASE_ADDR(BASE),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_SND_CSUM_ERR(err_p[0]),
      .I_RCV_CSUM_ERR(err_p[1]), .I_SND_ACC_ERR(err_p[2]),
      .I_RCV_ACC_ERR(err_p[3]), .I_SND_VLD(svld), .I_SND_VEC(svec),
      .I_RCV_VLD(rvld), .I_RCV_VEC(rvec), .O_INT_REQ(ireq),
      .O_INT_VEC(ivec), .I_CORE_ACCEPT(acc), .I_CORE_REFUSE(refu));

   liet_core_model cm (.i_clk(clk), .i_rst(rst), .i_req(ireq),
      .i_vec(ivec), .i_lat(lat), .i_refuse_one(ref_one), .o_accept(acc),
      .o_refuse(refu), .o_irr_vec(irr_vec), .o_acc_cnt(acc_cnt),
      .o_ref_cnt(ref_cnt));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rng(input logic [31:0] got, lo, hi);
      total_checks++;
      if (got < lo || got > hi)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
      if (n >= 16)
      begin
         miscompares++;
         close_out();
      end
   endtask

   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      apb(1'b1, {BASE, o}, d);
   endtask

   task automatic rd(input logic [11:0] o, input logic [31:0] x);
      apb(1'b0, {BASE, o}, 32'h0);
      chk(q, x);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input int i);
      err_p[i] <= 1'b1;
      @(posedge clk);
      err_p <= 4'h0;
   endtask

   task automatic send(input logic s, input logic [7:0] v);
      svld <= s;
      rvld <= !s;
      svec <= v;
      rvec <= v;
      @(posedge clk);
      svld <= 1'b0;
      rvld <= 1'b0;
   endtask

   task automatic wait_acc(input int t);
      int n;
      n = 0;
      while (acc_cnt < t && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      if (acc_cnt < t)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, acc_cnt, t);
         close_out();
      end
   endtask

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial
   begin
      {rst, psel, pen, pwr, svld, rvld, ref_one} = 7'b1000000;
      {paddr, pwdata, err_p, lat, svec, rvec} = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 6; i++)
         rd(offs[i], rstv[i]);
      apb(1'b1, {BASE + 20'h1, `LIET_OFF_INIT_CNT}, 32'h55);
      chk({31'h0, e}, 32'h1);
      rd(`LIET_OFF_INIT_CNT, 32'h0);
      wr(`LIET_OFF_ERR_LVT, 32'h40);
      pulse(0);
      wait_acc(1);
      chk({24'h0, irr_vec}, 32'h40);
      pulse(0);
      idle(10);
      chk(acc_cnt, 1);
      for (int i = 1; i < 4; i++)
      begin
         pulse(i);
         wait_acc(i + 1);
      end
      send(1'b1, 8'h10);
      idle(10);
      chk(acc_cnt, 4);
      send(1'b1, 8'h0f);
      wait_acc(5);
      send(1'b0, 8'h00);
      wait_acc(6);
      rd(12'h000, 32'h0);
      wait_acc(7);
      rd(`LIET_OFF_ESR, 32'h0);
      wr(`LIET_OFF_ESR, 32'h0);
      rd(`LIET_OFF_ESR, 32'hef);
      wr(`LIET_OFF_ESR, 32'h0);
      wr(`LIET_OFF_ESR, 32'h0);
      rd(`LIET_OFF_ESR, 32'h0);
      pulse(0);
      wait_acc(8);
      wr(`LIET_OFF_ERR_LVT, 32'h0001_0040);
      pulse(1);
      idle(10);
      chk(acc_cnt, 8);
      wr(`LIET_OFF_ESR, 32'h0);
      rd(`LIET_OFF_ESR, 32'h1);
      wr(`LIET_OFF_TMR_LVT, 32'h50);
      wr(`LIET_OFF_INIT_CNT, 32'd12);
      wait_acc(9);
      chk({24'h0, irr_vec}, 32'h50);
      idle(30);
      chk(acc_cnt, 9);
      rd(`LIET_OFF_CUR_CNT, 32'h0);
      wr(`LIET_OFF_CUR_CNT, 32'h1234);
      rd(`LIET_OFF_CUR_CNT, 32'h0);
      rd(`LIET_OFF_INIT_CNT, 32'd12);
      wr(`LIET_OFF_DIV_CFG, 32'h4);
      wr(`LIET_OFF_INIT_CNT, 32'd100);
      idle(40);
      apb(1'b0, {BASE, `LIET_OFF_CUR_CNT}, 32'h0);
      rng(q, 32'd86, 32'd92);
      wr(`LIET_OFF_DIV_CFG, 32'h1);
      wr(`LIET_OFF_INIT_CNT, 32'hffff_fff0);
      idle(50);
      wr(`LIET_OFF_INIT_CNT, 32'hffff_fff0);
      apb(1'b0, {BASE, `LIET_OFF_CUR_CNT}, 32'h0);
      rng(q, 32'hffff_ffe0, 32'hffff_fff0);
      wr(`LIET_OFF_TMR_LVT, 32'h0002_0050);
      wr(`LIET_OFF_INIT_CNT, 32'd20);
      wait_acc(10);
      wait_acc(11);
      apb(1'b0, {BASE, `LIET_OFF_CUR_CNT}, 32'h0);
      rng(q, 32'd1, 32'd20);
      wr(`LIET_OFF_INIT_CNT, 32'h0);
      wr(`LIET_OFF_TMR_LVT, 32'h50);
      ref_one <= 1'b1;
      lat <= 4'h3;
      wr(`LIET_OFF_INIT_CNT, 32'd5);
      wait_acc(12);
      chk(ref_cnt, 1);
      chk({24'h0, irr_vec}, 32'h50);
      ref_one <= 1'b0;
      wr(`LIET_OFF_TMR_LVT, 32'h0001_0050);
      wr(`LIET_OFF_INIT_CNT, 32'd5);
      idle(30);
      chk(acc_cnt, 12);
      close_out();
   end

endmodule
